// >>> hdl/ctc_pkg.sv
// constants for the charger top-off and termination voltage configuration bank
package ctc_pkg;
    // ==============================================================
    // register map
    localparam logic [7:0] ADDR_TOPOFF = 8'h19;
    localparam logic [7:0] ADDR_CV_VOLTAGE = 8'h1a;
    localparam int POS_SYS_FOLLOW_DIS = 7;
    localparam int POS_OVC_DEBOUNCE = 6;
    localparam int POS_DURATION_LSB = 3;
    localparam int POS_THRESHOLD_LSB = 0;
    localparam int POS_CV_LSB = 0;
    localparam int POS_SPARE_LSB = 6;
    localparam logic [7:0] RST_TOPOFF = 8'h98;
    localparam logic [7:0] RST_CV_VOLTAGE = 8'h00;
    // ==============================================================
    // decode constants
    localparam logic [12:0] THRESH_BASE_MA = 13'h0064;
    localparam logic [12:0] THRESH_STEP_MA = 13'h0064;
    localparam logic [2:0] THRESH_MAX_CODE = 3'h5;
    localparam logic [13:0] CV_BASE_MV = 14'h1f40;
    localparam logic [13:0] CV_STEP_MV = 14'h0014;
    localparam logic [12:0] DURATION_SHORT_S = 13'h001e;
    localparam logic [12:0] DURATION_STEP_S = 13'h0258;
    localparam int TRACK_PCT = 104;
    // ==============================================================
    // timing
    localparam int CLK_KHZ = 100000;
    localparam int OCP_SHORT_MS = 6;
    localparam int OCP_LONG_MS = 100;
    localparam int OCP_SHORT_CYCLES = OCP_SHORT_MS * CLK_KHZ;
    localparam int OCP_LONG_CYCLES = OCP_LONG_MS * CLK_KHZ;
    localparam int CYCLES_PER_SEC = CLK_KHZ * 1000;
    // ==============================================================
    // detail status codes and top-off state encoding
    localparam logic [3:0] DETAIL_OTHER = 4'h0;
    localparam logic [3:0] DETAIL_TOPOFF = 4'h4;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_TOPOFF = 2'b10
    } ctc_state_e;
endpackage : ctc_pkg

// >>> hdl/ctc_topoff_timer.sv
// top-off timer counting whole seconds of the selected duration
`timescale 1ns/1ps
`default_nettype none
module ctc_topoff_timer #(
    parameter int TICKS_PER_SEC = ctc_pkg::CYCLES_PER_SEC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic active,
    input wire logic [12:0] duration_s,
    output logic expired
);
    import ctc_pkg::*;
    logic [31:0] tick_q;
    logic [12:0] sec_q;
    logic run_q;
    wire tick_wrap = (tick_q == 32'(TICKS_PER_SEC - 1));
    wire reached = (sec_q >= duration_s);

    // ==============================================================
    // counters
    // restart on entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_q <= 32'h0;
            sec_q <= 13'h0;
            run_q <= 1'b0;
        end else if (start) begin
            tick_q <= 32'h0;
            sec_q <= 13'h0;
            run_q <= 1'b1;
        end else if (!active || reached) begin
            run_q <= 1'b0;
        end else if (run_q) begin
            tick_q <= tick_wrap ? 32'h0 : tick_q + 32'h1;
            if (tick_wrap) begin
                sec_q <= sec_q + 13'h1;
            end
        end
    end
    assign expired = active && !run_q && !start;
endmodule : ctc_topoff_timer
`default_nettype wire

// >>> hdl/ctc_topoff_cv_config.sv
// charger top-off and termination voltage configuration registers
`timescale 1ns/1ps
`default_nettype none
module ctc_topoff_cv_config #(
    parameter int OCP_SHORT = ctc_pkg::OCP_SHORT_CYCLES,
    parameter int OCP_LONG = ctc_pkg::OCP_LONG_CYCLES,
    parameter int TICKS_PER_SEC = ctc_pkg::CYCLES_PER_SEC
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic [12:0] CHARGE_CURRENT_MA,
    input wire logic CV_MODE,
    input wire logic [13:0] VBATT_MV,
    input wire logic [13:0] SYSTEM_VOLTAGE_FLOOR_MV,
    input wire logic BATT_SYS_OVERCURRENT,
    input wire logic TEMPERATURE_PROFILE_ENABLE,
    input wire logic TEMP_WARM,
    input wire logic [5:0] COOL_TERMINATION_VOLTAGE,
    input wire logic [5:0] WARM_TERMINATION_VOLTAGE,
    output logic [14:0] SYS_TARGET_MV,
    output logic [13:0] TERMINATION_MV,
    output logic [12:0] TOPOFF_THRESHOLD_MA,
    output logic SWITCHER_DISABLE,
    output logic CHARGER_EVENT_INTERRUPT,
    output logic [3:0] CHARGER_DETAIL_STATUS,
    output logic TOPOFF_TIMER_EXPIRED
);
    import ctc_pkg::*;
    localparam int SW = 13 + 1 + 14 + 14 + 1 + 1 + 1 + 6 + 6;

    // ==============================================================
    // input synchroniser
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    wire [SW-1:0] raw = {CHARGE_CURRENT_MA, CV_MODE, VBATT_MV, SYSTEM_VOLTAGE_FLOOR_MV,
        BATT_SYS_OVERCURRENT, TEMPERATURE_PROFILE_ENABLE, TEMP_WARM,
        COOL_TERMINATION_VOLTAGE, WARM_TERMINATION_VOLTAGE};
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end
    wire [12:0] s_current = sync_q[SW-1 -: 13];
    wire s_cv_mode = sync_q[SW-14];
    wire [13:0] s_vbatt = sync_q[SW-15 -: 14];
    wire [13:0] s_floor = sync_q[SW-29 -: 14];
    wire s_ovc = sync_q[14];
    wire s_prof_en = sync_q[13];
    wire s_warm = sync_q[12];
    wire [5:0] s_cool_code = sync_q[11:6];
    wire [5:0] s_warm_code = sync_q[5:0];

    // ==============================================================
    // registers
    logic [7:0] topoff_q;
    logic [7:0] cv_q;
    logic [7:0] rdata_q;
    wire wr_topoff = REG_WR && (REG_ADDR == ADDR_TOPOFF);
    wire wr_cv = REG_WR && (REG_ADDR == ADDR_CV_VOLTAGE);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            topoff_q <= RST_TOPOFF;
            cv_q <= RST_CV_VOLTAGE;
        end else begin
            if (wr_topoff) begin
                topoff_q <= REG_WDATA;
            end
            if (wr_cv) begin
                cv_q <= REG_WDATA;
            end
        end
    end
    wire sys_follow_disable = topoff_q[POS_SYS_FOLLOW_DIS];
    wire batt_sys_overcurrent_debounce = topoff_q[POS_OVC_DEBOUNCE];
    wire [2:0] topoff_duration = topoff_q[POS_DURATION_LSB +: 3];
    wire [2:0] topoff_current_threshold = topoff_q[POS_THRESHOLD_LSB +: 3];
    wire [5:0] charge_termination_voltage = cv_q[POS_CV_LSB +: 6];

    // ==============================================================
    // readback
    // threshold read returns live field
    wire [7:0] rd_mux = (REG_ADDR == ADDR_TOPOFF) ? topoff_q :
        (REG_ADDR == ADDR_CV_VOLTAGE) ? cv_q : 8'h00;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_mux;
        end
    end
    assign REG_RDATA = rdata_q;

    // ==============================================================
    // decoders
    // threshold saturates at 600 mA
    wire [2:0] thr_code = (topoff_current_threshold > THRESH_MAX_CODE) ?
        THRESH_MAX_CODE : topoff_current_threshold;
    wire [12:0] thr_ma = THRESH_BASE_MA + 13'(THRESH_STEP_MA * thr_code);
    // profile enable selects cool or warm code
    wire [5:0] cv_code = s_prof_en ? (s_warm ? s_warm_code : s_cool_code) :
        charge_termination_voltage;
    // 8.000 V base, 20 mV per step
    wire [13:0] cv_mv = CV_BASE_MV + 14'(CV_STEP_MV * cv_code);
    wire [12:0] dur_s = (topoff_duration == 3'h0) ? DURATION_SHORT_S :
        13'(DURATION_STEP_S * topoff_duration);
    wire [20:0] batt_scaled = 21'(s_vbatt) * 21'(TRACK_PCT);
    wire [14:0] batt_track = 15'(batt_scaled / 21'd100);
    wire [14:0] track_mv = (batt_track > 15'(s_floor)) ? batt_track : 15'(s_floor);
    wire [14:0] sys_mv = sys_follow_disable ? 15'(cv_mv) : track_mv;

    // ==============================================================
    // overcurrent debounce
    logic [31:0] ovc_cnt_q;
    logic sw_dis_q;
    wire [31:0] ovc_limit = batt_sys_overcurrent_debounce ? 32'(OCP_LONG) : 32'(OCP_SHORT);
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ovc_cnt_q <= 32'h0;
            sw_dis_q <= 1'b0;
        end else if (!s_ovc) begin
            ovc_cnt_q <= 32'h0;
            sw_dis_q <= 1'b0;
        end else if (ovc_cnt_q < ovc_limit - 32'h1) begin
            ovc_cnt_q <= ovc_cnt_q + 32'h1;
        end else begin
            sw_dis_q <= 1'b1;
        end
    end

    // ==============================================================
    // top-off state machine
    ctc_state_e state_q;
    ctc_state_e state_d;
    logic irq_q;
    wire enter_topoff = (state_q == ST_IDLE) && s_cv_mode && (s_current <= thr_ma);
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (enter_topoff) begin
                    state_d = ST_TOPOFF;
                end
            end
            ST_TOPOFF: begin
                if (!s_cv_mode) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            irq_q <= enter_topoff;
        end
    end
    wire in_topoff = (state_q == ST_TOPOFF);

    ctc_topoff_timer #(
        .TICKS_PER_SEC(TICKS_PER_SEC)
    ) u_timer (
        .clk(CLK),
        .resetn(RESETN),
        .start(irq_q),
        .active(in_topoff),
        .duration_s(dur_s),
        .expired(TOPOFF_TIMER_EXPIRED)
    );

    // ==============================================================
    // output flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            SYS_TARGET_MV <= 15'h0;
            TERMINATION_MV <= 14'h0;
            TOPOFF_THRESHOLD_MA <= 13'h0;
        end else begin
            SYS_TARGET_MV <= sys_mv;
            TERMINATION_MV <= cv_mv;
            TOPOFF_THRESHOLD_MA <= thr_ma;
        end
    end
    assign SWITCHER_DISABLE = sw_dis_q;
    assign CHARGER_EVENT_INTERRUPT = irq_q;
    assign CHARGER_DETAIL_STATUS = in_topoff ? DETAIL_TOPOFF : DETAIL_OTHER;

    // ==============================================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_irq_on_entry: assert property (
        enter_topoff |=> CHARGER_EVENT_INTERRUPT ##0 in_topoff)
        else $error("interrupt missing on top-off entry");
    a_detail_topoff: assert property (
        CHARGER_EVENT_INTERRUPT |-> CHARGER_DETAIL_STATUS == DETAIL_TOPOFF)
        else $error("detail status not top-off");
    a_irq_single: assert property (CHARGER_EVENT_INTERRUPT |=> !CHARGER_EVENT_INTERRUPT)
        else $error("interrupt longer than one cycle");
    a_entry_cause: assert property (
        $rose(in_topoff) |-> $past(s_cv_mode) && $past(s_current) <= $past(thr_ma))
        else $error("top-off entered without current decay");
    a_thresh_sat: assert property (
        topoff_current_threshold >= 3'h5 |=> TOPOFF_THRESHOLD_MA == 13'd600)
        else $error("threshold not saturated at 600 mA");
    // sampled reset term skips the release edge, outputs still at reset there
    a_cv_decode: assert property (
        RESETN && !s_prof_en |=>
        TERMINATION_MV == 14'd8000 + 14'd20 * 14'($past(charge_termination_voltage)))
        else $error("termination voltage decode wrong");
    a_track_off: assert property (
        sys_follow_disable ##1 sys_follow_disable |-> SYS_TARGET_MV == 15'(TERMINATION_MV))
        else $error("system rail not at termination voltage");
    a_track_floor: assert property (
        !sys_follow_disable |=> SYS_TARGET_MV >= 15'($past(s_floor)))
        else $error("system rail below floor while tracking");
    a_ovc_clear: assert property (!s_ovc |=> !SWITCHER_DISABLE)
        else $error("switcher disabled without overcurrent");
    a_ovc_trip: assert property (
        $rose(SWITCHER_DISABLE) |-> $past(ovc_cnt_q) == ovc_limit - 32'h1)
        else $error("switcher disabled before debounce time");
    a_read_thresh: assert property (
        REG_ADDR == ADDR_TOPOFF |=> REG_RDATA[2:0] == $past(topoff_current_threshold))
        else $error("threshold readback differs");
    a_timer_start: assert property (CHARGER_EVENT_INTERRUPT |=> !TOPOFF_TIMER_EXPIRED)
        else $error("timer expired at start");
    c_topoff: cover property (enter_topoff);
    c_expire: cover property (in_topoff ##1 TOPOFF_TIMER_EXPIRED);
    c_ovc: cover property ($rose(SWITCHER_DISABLE));
endmodule : ctc_topoff_cv_config
`default_nettype wire

// >>> dv/ctc_topoff_cv_config_tb.sv
// self-checking bench for the top-off and termination voltage bank
`timescale 1ns/1ps
`default_nettype none
module ctc_topoff_cv_config_tb;
    import ctc_pkg::*;
    localparam int TPS = 4;
    logic clk, resetn, reg_wr, cv_mode, ovc, prof_en, temp_warm, sw_dis, irq, expired;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [12:0] cur_ma, thr_ma;
    logic [13:0] vbatt, vfloor, term_mv;
    logic [5:0] cool_cv, warm_cv, code;
    logic [14:0] sys_mv;
    logic [3:0] detail;
    int mismatches, check_count, irq_count;

    ctc_topoff_cv_config #(.OCP_SHORT(6), .OCP_LONG(100), .TICKS_PER_SEC(TPS)) uut (
        .CLK(clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CHARGE_CURRENT_MA(cur_ma),
        .CV_MODE(cv_mode), .VBATT_MV(vbatt), .SYSTEM_VOLTAGE_FLOOR_MV(vfloor),
        .BATT_SYS_OVERCURRENT(ovc), .TEMPERATURE_PROFILE_ENABLE(prof_en),
        .TEMP_WARM(temp_warm), .COOL_TERMINATION_VOLTAGE(cool_cv),
        .WARM_TERMINATION_VOLTAGE(warm_cv), .SYS_TARGET_MV(sys_mv),
        .TERMINATION_MV(term_mv), .TOPOFF_THRESHOLD_MA(thr_ma), .SWITCHER_DISABLE(sw_dis),
        .CHARGER_EVENT_INTERRUPT(irq), .CHARGER_DETAIL_STATUS(detail),
        .TOPOFF_TIMER_EXPIRED(expired)
    );

    // ==============================================================
    // clock, watchdog, interrupt pulse counter
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
    always @(negedge clk) begin
        if (irq === 1'b1) irq_count++;
    end

    // ==============================================================
    // helper tasks
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        settle(3);
        v = reg_rdata;
    endtask : rd
    task automatic ocp(input logic [7:0] cfg, input int lim);
        wr(8'h19, cfg);
        @(posedge clk);
        ovc <= 1'b1;
        settle(lim + 1);
        check(16'(sw_dis), 16'h0);
        settle(1);
        check(16'(sw_dis), 16'h1);
        @(posedge clk);
        ovc <= 1'b0;
        settle(2);
        check(16'(sw_dis), 16'h1);
        settle(1);
        check(16'(sw_dis), 16'h0);
    endtask : ocp
    task automatic topoff(input logic [7:0] cfg, input logic [12:0] ma, input int dur);
        int n;
        int k;
        wr(8'h19, cfg);
        cur_ma <= 13'd1000;
        cv_mode <= 1'b1;
        settle(6);
        check(16'(detail), 16'h0);
        k = irq_count;
        @(posedge clk);
        cur_ma <= ma;
        n = 0;
        do begin
            settle(1);
            n++;
        end while (irq !== 1'b1 && n < 10);
        check(16'(irq), 16'h1);
        check(16'(n), 16'h3);
        check(16'(detail), 16'(DETAIL_TOPOFF));
        settle(dur + 1);
        check(16'(expired), 16'h0);
        settle(1);
        check(16'(expired), 16'h1);
        check(16'(detail), 16'(DETAIL_TOPOFF));
        check(16'(irq_count - k), 16'h1);
        @(posedge clk);
        cv_mode <= 1'b0;
        cur_ma <= 13'd1000;
        settle(5);
        check(16'(detail), 16'h0);
        check(16'(expired), 16'h0);
    endtask : topoff

    // ==============================================================
    // test sequence
    initial begin : main
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        cur_ma = 13'd1000;
        cv_mode = 1'b0;
        vbatt = 14'd8000;
        vfloor = 14'd6000;
        ovc = 1'b0;
        prof_en = 1'b0;
        temp_warm = 1'b0;
        cool_cv = 6'h00;
        warm_cv = 6'h00;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        settle(4);
        rd(8'h19, d);
        check(16'(d), 16'h98);
        rd(8'h1a, d);
        check(16'(d), 16'h00);
        check(16'(term_mv), 16'd8000);
        check(16'(sys_mv), 16'd8000);
        check(16'(thr_ma), 16'd100);
        wr(8'h1b, 8'h55);
        rd(8'h1b, d);
        check(16'(d), 16'h00);
        for (int i = 0; i < 4; i++) begin
            code = (i == 3) ? 6'h3f : 6'(i * 21);
            wr(8'h1a, {2'(i), code});
            rd(8'h1a, d);
            check(16'(d), 16'({2'(i), code}));
            check(16'(term_mv), 16'(8000 + 20 * code));
            check(16'(sys_mv), 16'(8000 + 20 * code));
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'h19, 8'h98 | 8'(i));
            rd(8'h19, d);
            check(16'(d), 16'(8'h98 | 8'(i)));
            check(16'(thr_ma), 16'((i > 5) ? 600 : 100 * (i + 1)));
        end
        wr(8'h19, 8'h18);
        settle(5);
        check(16'(sys_mv), 16'd8320);
        @(posedge clk);
        vfloor <= 14'd9000;
        cool_cv <= 6'd10;
        warm_cv <= 6'd20;
        prof_en <= 1'b1;
        settle(5);
        check(16'(sys_mv), 16'd9000);
        check(16'(term_mv), 16'd8200);
        @(posedge clk);
        temp_warm <= 1'b1;
        settle(5);
        check(16'(term_mv), 16'd8400);
        @(posedge clk);
        prof_en <= 1'b0;
        settle(5);
        check(16'(term_mv), 16'd9260);
        ocp(8'h98, 6);
        ocp(8'hd8, 100);
        topoff(8'h82, 13'd300, 30 * TPS);
        topoff(8'h8b, 13'd400, 600 * TPS);
        complete_run();
    end
endmodule : ctc_topoff_cv_config_tb
`default_nettype wire
